/* File: hw/adc_dyn.sv */
`timescale 1ns/1ps
`include "adc_consts.svh"
module adc_dyn
  import adc_pkg::*;
(
  input wire logic MCLK, // 10 MHz device clock
  input wire logic RST_B, // Asynchronous reset, active low
  input wire logic [9:0] ADDR, // Register address
  input wire logic [21:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  output logic [21:0] RDATA, // Read data, cycle after RD
  input wire logic S_VALID, // One pulse per audio sample
  input wire adc_smp_t L_IN, // Left sample
  input wire adc_smp_t R_IN, // Right sample
  output adc_smp_t L_OUT, // Left result
  output adc_smp_t R_OUT, // Right result
  output adc_smp_t SUB_OUT, // Subwoofer result
  output logic O_VALID // Results updated
);
  logic rst_s1_r, rst_n;
  logic [21:0] pram [0:255];
  logic [13:0] ctrl1_r;
  logic [21:0] rdata_r;
  adc_state_t state_r;
  logic [2:0] cnt_r;
  adc_smp_t mid_r, vin_r, ys_r, sub_out_r;
  adc_smp_t bx1_r, bx2_r, by1_r, by2_r;
  logic [6:0] wp_r;
  adc_coef_t gm_r, gs_r;
  logic o_valid_r;
  adc_smp_t in_l, in_r;
  adc_smp_t ch_out [0:1];

  //////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register port decode
  wire ram_hit = (ADDR <= `ADC_RAM_TOP);
  wire ctrl_hit = (ADDR == `ADC_A_CTRL1);
  wire stat_hit = (ADDR == `ADC_A_STATUS);
  wire [1:0] de_sel = ctrl1_r[`ADC_DEEM_HI:`ADC_DEEM_LO];
  wire [21:0] rd_nxt = ram_hit ? pram[ADDR[7:0]] :
                       ctrl_hit ? {20'h00000, de_sel} :
                       stat_hit ? gm_r : 22'h000000;

  // Parameter memory; every word is kept at its full 22 bits
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) pram[i] <= 22'h000000;
    end else if (WR && ram_hit) begin
      pram[ADDR[7:0]] <= WDATA;
    end
  end

  // Control register one keeps the low 14 bits written
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) ctrl1_r <= 14'h0000;
    else if (WR && ctrl_hit) ctrl1_r <= WDATA[`ADC_CTRL1_W-1:0];
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) rdata_r <= 22'h000000;
    else rdata_r <= RD ? rd_nxt : 22'h000000;
  end

  //////////////////////////////////////////////////////////////////////
  // Parameter views
  wire adc_coef_t p_post = pram[`ADC_P_POST];
  wire adc_coef_t p_wl = pram[`ADC_P_WL];
  wire adc_coef_t p_wr = pram[`ADC_P_WR];
  wire adc_coef_t bq_b0 = pram[`ADC_P_BQ];
  wire adc_coef_t bq_b1 = pram[`ADC_P_BQ + 8'h01];
  wire adc_coef_t bq_b2 = pram[`ADC_P_BQ + 8'h02];
  wire adc_coef_t bq_a1 = pram[`ADC_P_BQ + 8'h03];
  wire adc_coef_t bq_a2 = pram[`ADC_P_BQ + 8'h04];
  wire [21:0] la_raw = pram[`ADC_P_LA];
  // Values above ADC_LA_MAX (100) are clipped to that longest delay
  wire [6:0] la = (la_raw > {15'h0000, `ADC_LA_MAX}) ? `ADC_LA_MAX : la_raw[6:0];
  wire [6:0] rp = wp_r - 7'h01 - la;

  //////////////////////////////////////////////////////////////////////
  // Input mixing: mid for main detector, weighted sum for sub
  wire logic signed [24:0] lr_sum = {L_IN[23], L_IN} + {R_IN[23], R_IN};
  wire adc_smp_t mid_nxt = lr_sum[24:1];
  wire adc_acc_t vin_acc = 49'(L_IN * p_wl) + 49'(R_IN * p_wr);
  wire adc_smp_t vin_nxt = adc_satq(vin_acc);

  // Sub detector biquad, direct form one
  wire adc_acc_t bq_acc = 49'(vin_r * bq_b0) + 49'(bx1_r * bq_b1) + 49'(bx2_r * bq_b2)
                        - 49'(by1_r * bq_a1) - 49'(by2_r * bq_a2);
  wire adc_smp_t bq_y = adc_satq(bq_acc);
  wire det_stb = (state_r == ST_BQ);

  //////////////////////////////////////////////////////////////////////
  // Level detectors; sub path sees only the filtered copy
  logic [5:0] idx_m, idx_s;
  logic [7:0] frac_m, frac_s;

  adc_det u_det_m (
    .clk(MCLK),
    .rst_n(rst_n),
    .stb(det_stb),
    .x(mid_r),
    .tconst(pram[`ADC_P_TC_M]),
    .hold(pram[`ADC_P_HOLD_M]),
    .decay(pram[`ADC_P_DECAY_M]),
    .idx(idx_m),
    .frac(frac_m)
  );

  adc_det u_det_s (
    .clk(MCLK),
    .rst_n(rst_n),
    .stb(det_stb),
    .x(bq_y),
    .tconst(pram[`ADC_P_TC_S]),
    .hold(pram[`ADC_P_HOLD_S]),
    .decay(pram[`ADC_P_DECAY_S]),
    .idx(idx_s),
    .frac(frac_s)
  );

  //////////////////////////////////////////////////////////////////////
  // Upper neighbour of a table index, held at the last entry
  function automatic logic [5:0] nxt_idx(input logic [5:0] idx);
    return (idx >= `ADC_TAB_LAST) ? `ADC_TAB_LAST : idx + 6'h01;
  endfunction

  // Linear interpolation; entries come in as arguments so table writes wake the wires
  function automatic logic [21:0] interp(input logic [21:0] e0, input logic [21:0] e1,
                                         input logic [7:0] frac);
    logic signed [22:0] t0, t1;
    logic signed [31:0] step;
    t0 = {1'b0, e0};
    t1 = {1'b0, e1};
    step = 32'((t1 - t0) * $signed({1'b0, frac})) >>> 8;
    return 22'(32'(t0) + step);
  endfunction

  wire [5:0] i1_m = nxt_idx(idx_m);
  wire [5:0] i1_s = nxt_idx(idx_s);
  wire [21:0] gm_e0 = pram[8'(`ADC_TAB_M + {2'h0, idx_m})];
  wire [21:0] gm_e1 = pram[8'(`ADC_TAB_M + {2'h0, i1_m})];
  wire [21:0] gs_e0 = pram[8'(`ADC_TAB_S + {2'h0, idx_s})];
  wire [21:0] gs_e1 = pram[8'(`ADC_TAB_S + {2'h0, i1_s})];
  wire [21:0] gm_nxt = interp(gm_e0, gm_e1, frac_m);
  wire [21:0] gs_nxt = interp(gs_e0, gs_e1, frac_s);

  // De-emphasis coefficient pick; k 0 is b0, 1 is b1, 2 is a1
  function automatic adc_coef_t de_coef(input logic [1:0] sel, input logic [1:0] k);
    case (sel)
      `ADC_DE_32K: return (k == 2'h0) ? `ADC_DE32_B0 : (k == 2'h1) ? `ADC_DE32_B1 : `ADC_DE32_A1;
      `ADC_DE_44K: return (k == 2'h0) ? `ADC_DE44_B0 : (k == 2'h1) ? `ADC_DE44_B1 : `ADC_DE44_A1;
      `ADC_DE_48K: return (k == 2'h0) ? `ADC_DE48_B0 : (k == 2'h1) ? `ADC_DE48_B1 : `ADC_DE48_A1;
      default: return 22'sh000000;
    endcase
  endfunction

  wire adc_coef_t de_b0 = de_coef(de_sel, 2'h0);
  wire adc_coef_t de_b1 = de_coef(de_sel, 2'h1);
  wire adc_coef_t de_a1 = de_coef(de_sel, 2'h2);

  //////////////////////////////////////////////////////////////////////
  // Sequencer: one pass per sample, about ten clocks of a long frame
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
    end else begin
      case (state_r)
        ST_IDLE: if (S_VALID) state_r <= ST_BQ;
        ST_BQ: state_r <= ST_WAIT;
        ST_WAIT: state_r <= ST_GAIN;
        ST_GAIN: begin
          state_r <= ST_POST;
          cnt_r <= 3'h0;
        end
        ST_POST: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == `ADC_POST_LAST) state_r <= ST_DEEM;
        end
        ST_DEEM: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Captured mix values and sub biquad history
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      {mid_r, vin_r} <= {24'sh000000, 24'sh000000};
      {bx1_r, bx2_r, by1_r, by2_r} <= {4{24'sh000000}};
    end else if (state_r == ST_IDLE && S_VALID) begin
      mid_r <= mid_nxt;
      vin_r <= vin_nxt;
    end else if (state_r == ST_BQ) begin
      {bx2_r, bx1_r} <= {bx1_r, vin_r};
      {by2_r, by1_r} <= {by1_r, bq_y};
    end
  end

  // Gains, sub output path and write pointer
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      {gm_r, gs_r} <= {22'sh000000, 22'sh000000};
      {ys_r, sub_out_r} <= {24'sh000000, 24'sh000000};
      wp_r <= 7'h00;
      o_valid_r <= 1'b0;
    end else begin
      if (state_r == ST_BQ) wp_r <= wp_r + 7'h01;
      if (state_r == ST_WAIT) {gm_r, gs_r} <= {gm_nxt, gs_nxt};
      if (state_r == ST_GAIN) ys_r <= adc_mulq(vin_r, gs_r);
      if (state_r == ST_DEEM) sub_out_r <= ys_r;
      o_valid_r <= (state_r == ST_DEEM);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Per main channel: look-ahead line, gain, post gain, de-emphasis
  assign in_l = L_IN;
  assign in_r = R_IN;

  for (genvar g = 0; g < 2; g++) begin : g_ch
    adc_smp_t mem [0:127];
    adc_smp_t in_c_r, dl_r, w_r, x1_r, y1_r, out_r;
    wire adc_smp_t in_c = (g == 0) ? in_l : in_r;
    // Shelf stays off the biquad bank so no filter slot is lost
    wire adc_acc_t de_acc = 49'(w_r * de_b0) + 49'(x1_r * de_b1) - 49'(y1_r * de_a1);
    wire adc_smp_t de_y = adc_satq(de_acc);
    wire de_on = (de_sel != `ADC_DE_OFF);

    // Look-ahead line; the detector already saw this sample
    always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
        for (int i = 0; i < 128; i++) mem[i] <= 24'sh000000;
      end else if (state_r == ST_BQ) begin
        mem[wp_r] <= in_c_r;
      end
    end

    // Gain multiply, then five post-gain multiplies
    always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
        {in_c_r, dl_r, w_r} <= {3{24'sh000000}};
      end else begin
        if (state_r == ST_IDLE && S_VALID) in_c_r <= in_c;
        if (state_r == ST_WAIT) dl_r <= mem[rp];
        if (state_r == ST_GAIN) w_r <= adc_mulq(dl_r, gm_r);
        if (state_r == ST_POST) w_r <= adc_mulq(w_r, p_post);
      end
    end

    // De-emphasis history is cleared while bypassed to avoid a step on enable
    always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
        {x1_r, y1_r, out_r} <= {3{24'sh000000}};
      end else if (state_r == ST_DEEM) begin
        x1_r <= de_on ? w_r : 24'sh000000;
        y1_r <= de_on ? de_y : 24'sh000000;
        out_r <= de_on ? de_y : w_r;
      end
    end

    assign ch_out[g] = out_r;
  end

  assign L_OUT = ch_out[0];
  assign R_OUT = ch_out[1];
  assign SUB_OUT = sub_out_r;
  assign O_VALID = o_valid_r;
  assign RDATA = rdata_r;
endmodule // adc_dyn

/* File: hw/adc_consts.svh */
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH
// Register port map
`define ADC_A_CTRL1 10'h100
`define ADC_A_STATUS 10'h3F0
`define ADC_RAM_TOP 10'h0FF
`define ADC_CTRL1_W 14
`define ADC_DEEM_HI 5
`define ADC_DEEM_LO 4
// Parameter memory locations, main compressor
`define ADC_P_TC_M 8'h64
`define ADC_P_HOLD_M 8'h65
`define ADC_P_DECAY_M 8'h66
`define ADC_P_LA 8'h67
`define ADC_P_POST 8'h68
`define ADC_TAB_M 8'h6E
// Parameter memory locations, subwoofer compressor
`define ADC_P_WL 8'h96
`define ADC_P_WR 8'h97
`define ADC_P_TC_S 8'h98
`define ADC_P_HOLD_S 8'h99
`define ADC_P_DECAY_S 8'h9A
`define ADC_P_BQ 8'h9B
`define ADC_TAB_S 8'hA0
// Datapath figures
`define ADC_FRAC 20
`define ADC_TAB_LAST 6'h20
`define ADC_LA_MAX 7'h64
`define ADC_POST_LAST 3'h4
`define ADC_LOG_OFS 8'h0D
// De-emphasis 2.20 coefficients: b0, b1, a1 per sample rate
`define ADC_DE32_B0 22'h077777
`define ADC_DE32_B1 22'h002702
`define ADC_DE32_A1 22'h379E7A
`define ADC_DE44_B0 22'h06DEC6
`define ADC_DE44_B1 22'h3F0B74
`define ADC_DE44_A1 22'h35EA3C
`define ADC_DE48_B0 22'h06BB28
`define ADC_DE48_B1 22'h3EC945
`define ADC_DE48_A1 22'h358467
// De-emphasis select codes
`define ADC_DE_OFF 2'h0
`define ADC_DE_32K 2'h1
`define ADC_DE_44K 2'h2
`define ADC_DE_48K 2'h3
`endif

/* File: hw/adc_pkg.sv */
`include "adc_consts.svh"
package adc_pkg;
  typedef logic signed [23:0] adc_smp_t;
  typedef logic signed [21:0] adc_coef_t;
  typedef logic signed [48:0] adc_acc_t;
  typedef enum logic [2:0] {ST_IDLE, ST_BQ, ST_WAIT, ST_GAIN, ST_POST, ST_DEEM} adc_state_t;

  // Drop 20 fraction bits and clip to the sample range
  function automatic adc_smp_t adc_satq(input adc_acc_t s);
    adc_acc_t t;
    t = s >>> `ADC_FRAC;
    if (t > 49'sh0007FFFFF) return 24'sh7FFFFF;
    if (t < -49'sh000800000) return -24'sh800000;
    return t[23:0];
  endfunction

  // Sample times 2.20 coefficient
  function automatic adc_smp_t adc_mulq(input adc_smp_t a, input adc_coef_t c);
    adc_acc_t p;
    p = 49'(a * c);
    return adc_satq(p);
  endfunction
endpackage

/* File: hw/adc_det.sv */
`timescale 1ns/1ps
`include "adc_consts.svh"
module adc_det
  import adc_pkg::*;
(
  input wire logic clk, // Device clock
  input wire logic rst_n, // Synchronised reset
  input wire logic stb, // One pulse per sample
  input wire adc_smp_t x, // Detector input
  input wire adc_coef_t tconst, // Smoothing coefficient
  input wire logic [21:0] hold, // Hold in samples
  input wire logic [21:0] decay, // Release step
  output logic [5:0] idx, // Table index 0..32
  output logic [7:0] frac // Interpolation fraction
);
  logic [23:0] ax;
  adc_smp_t sm_r, sm_nxt, diff;
  logic [4:0] msb;
  logic [23:0] norm;
  logic [15:0] lg;
  logic [13:0] lvl_new;
  logic [21:0] lvl_r, rel;
  logic [21:0] hold_r;

  // Leading one of the smoothed magnitude
  function automatic logic [4:0] lead1(input logic [23:0] v);
    logic [4:0] p;
    p = 5'h00;
    for (int i = 0; i < 24; i++) begin
      if (v[i]) p = 5'(i);
    end
    return p;
  endfunction

  // Clip magnitude so the most negative sample stays in range
  assign ax = x[23] ? ((x == -24'sh800000) ? 24'h7FFFFF : 24'(-x)) : x;
  assign diff = adc_smp_t'(ax) - sm_r;
  assign sm_nxt = sm_r + adc_mulq(diff, tconst);
  assign msb = lead1(sm_r);
  assign norm = sm_r << (5'h17 - msb);
  // Two steps per octave: one step is 3 dB of amplitude
  assign lg = {10'h000, msb, 1'b0} + {15'h0000, norm[22]};
  assign lvl_new = (lg < {8'h00, `ADC_LOG_OFS}) ? 14'h0000 :
                   (lg - {8'h00, `ADC_LOG_OFS} >= {10'h000, `ADC_TAB_LAST}) ?
                   {`ADC_TAB_LAST, 8'h00} :
                   {6'(lg - {8'h00, `ADC_LOG_OFS}), norm[21:15], 1'b0};
  assign rel = (lvl_r > decay) ? lvl_r - decay : 22'h000000;

  // Smoothing of the magnitude
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sm_r <= 24'sh000000;
    else if (stb) sm_r <= sm_nxt;
  end

  // Peak ride, then hold, then ramp down in the log domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_r <= 22'h000000;
      hold_r <= 22'h000000;
    end else if (stb) begin
      if ({lvl_new, 8'h00} >= lvl_r) begin
        lvl_r <= {lvl_new, 8'h00};
        hold_r <= hold;
      end else if (hold_r != 22'h000000) begin
        hold_r <= hold_r - 22'h000001;
      end else begin
        lvl_r <= rel;
      end
    end
  end

  assign idx = lvl_r[21:16];
  assign frac = lvl_r[15:8];
endmodule // adc_det

/* File: tb/adc_dyn_checker.sv */
`timescale 1ns/1ps
`include "adc_consts.svh"
module adc_dyn_checker
  import adc_pkg::*;
(
  input wire logic MCLK, // Clock
  input wire logic RST_B, // Reset, active low
  input wire logic [9:0] ADDR, // Address
  input wire logic [21:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  input wire logic [21:0] RDATA, // Read data
  input wire logic S_VALID, // Sample strobe
  input wire adc_smp_t L_OUT, // Left result
  input wire adc_smp_t R_OUT, // Right result
  input wire adc_smp_t SUB_OUT, // Sub result
  input wire logic O_VALID // Result strobe
);
  logic [3:0] busy_r;
  wire take = S_VALID && (busy_r == 4'h0);
  wire [1:0] sel_w = WDATA[5:4];
  // Pass tracker; strobes inside a pass are dropped by the block
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) busy_r <= 4'h0;
    else if (take) busy_r <= 4'h9;
    else if (busy_r != 4'h0) busy_r <= busy_r - 4'h1;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  sequence s_start;
    take;
  endsequence
  sequence s_done;
    ##10 O_VALID;
  endsequence
  a_pass_latency: assert property (s_start |-> s_done)
    else $error("result strobe late or missing");
  a_quiet_pass: assert property (s_start |=> (!O_VALID) [*8])
    else $error("result strobe inside a pass");
  a_valid_cause: assert property (O_VALID |-> $past(take, 10))
    else $error("result strobe without sample");
  a_valid_pulse: assert property (O_VALID |=> !O_VALID)
    else $error("result strobe too long");
  a_out_hold: assert property (!O_VALID |-> $stable(L_OUT) && $stable(R_OUT)
    && $stable(SUB_OUT))
    else $error("outputs moved between results");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 22'h0)
    else $error("read data outside its cycle");
  a_ctrl_width: assert property (RD && ADDR == `ADC_A_CTRL1 |=> RDATA[21:2] == 20'h0)
    else $error("control read wider than select");
  a_unmapped_zero: assert property (RD && ADDR > `ADC_A_CTRL1 && ADDR != `ADC_A_STATUS
    |=> RDATA == 22'h0)
    else $error("unmapped read not zero");
  a_param_rdback: assert property ((WR && ADDR <= `ADC_RAM_TOP) ##1
    (RD && ADDR == $past(ADDR)) |=> RDATA == $past(WDATA, 2))
    else $error("parameter word not kept");
  a_ctrl_rdback: assert property ((WR && ADDR == `ADC_A_CTRL1) ##1
    (RD && ADDR == `ADC_A_CTRL1) |=> RDATA == {20'h0, $past(sel_w, 2)})
    else $error("select field not kept");
endmodule // adc_dyn_checker

bind adc_dyn adc_dyn_checker u_chk (.MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .S_VALID(S_VALID), .L_OUT(L_OUT), .R_OUT(R_OUT),
  .SUB_OUT(SUB_OUT), .O_VALID(O_VALID));

/* File: tb/adc_src_model.sv */
`timescale 1ns/1ps
module adc_src_model
  import adc_pkg::*;
(
  input wire logic clk, // Device clock
  output logic s_valid, // Sample strobe
  output adc_smp_t l_smp, // Left sample
  output adc_smp_t r_smp // Right sample
);
  initial begin
    s_valid = 1'b0;
    l_smp = '0;
    r_smp = '0;
  end
  // One frame; lines show the inverse once the strobe drops
  task automatic send(input adc_smp_t l, input adc_smp_t r, input int gap);
    s_valid <= 1'b1;
    l_smp <= l;
    r_smp <= r;
    @(posedge clk);
    s_valid <= 1'b0;
    l_smp <= ~l;
    r_smp <= ~r;
    repeat (11 + gap) @(posedge clk);
  endtask
  ////////////////////////////////////////
  // Host conversions; truncation, never rounding
  function automatic logic [21:0] q220(input real v);
    return 22'($rtoi(v * 1048576.0));
  endfunction
  function automatic logic [21:0] tconst_word(input real rate, input real fs);
    rate = (rate > 0.0) ? -rate : rate;
    return q220(1.0 - 10.0 ** (rate / (10.0 * fs)));
  endfunction
  function automatic logic [21:0] decay_word(input real dbs);
    return 22'($rtoi(dbs / 1.096));
  endfunction
  function automatic logic [21:0] post_word(input real g);
    return q220(g ** 0.2);
  endfunction
  // Hold never shorter than look-ahead, or the tail swells
  function automatic logic [21:0] hold_word(input real t, input real fs, input int la);
    int h;
    h = $rtoi(fs * t);
    return 22'((h < la) ? la : h);
  endfunction
endmodule // adc_src_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`include "adc_consts.svh"
module testbench
  import adc_pkg::*;
;
  logic MCLK, RST_B, WR, RD, S_VALID, O_VALID;
  logic [9:0] ADDR;
  logic [21:0] WDATA, RDATA, post_c;
  adc_smp_t L_IN, R_IN, L_OUT, R_OUT, SUB_OUT;
  adc_smp_t hl[$], hr[$];
  int fail_count = 0;
  int comparisons = 0;
  int las[4] = '{0, 3, 100, 200};
  logic [31:0] lfsr_r = 32'h00012C1D; // Seed 76829

  adc_dyn dut (.MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .S_VALID(S_VALID), .L_IN(L_IN), .R_IN(R_IN), .L_OUT(L_OUT),
    .R_OUT(R_OUT), .SUB_OUT(SUB_OUT), .O_VALID(O_VALID));
  adc_src_model src (.clk(MCLK), .s_valid(S_VALID), .l_smp(L_IN), .r_smp(R_IN));
  ////////////////////////////////////////
  // Reference arithmetic, saturating like the datapath
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  function automatic adc_smp_t sat(input logic signed [47:0] v);
    if (v > 48'sh7FFFFF) return 24'sh7FFFFF;
    if (v < -48'sh800000) return 24'sh800000;
    return v[23:0];
  endfunction
  function automatic adc_smp_t post5(input adc_smp_t x, input adc_coef_t c);
    for (int i = 0; i < 5; i++) x = sat((48'(x) * 48'(c)) >>> 20);
    return x;
  endfunction
  ////////////////////////////////////////
  // Comparison, bus cycles and frames
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [9:0] a, input logic [21:0] v);
    WR <= w;
    RD <= r;
    ADDR <= a;
    WDATA <= v;
    @(posedge MCLK);
  endtask
  task automatic wr(input logic [9:0] a, input logic [21:0] v);
    bus(1'b1, 1'b0, a, v);
    bus(1'b0, 1'b0, a, v);
  endtask
  // Read data is looked at once settled in the single cycle it stands
  task automatic rchk(input string n, input logic [9:0] a, input logic [21:0] e);
    bus(1'b0, 1'b1, a, 22'h0);
    RD <= 1'b0;
    #1 check(n, RDATA, e);
    @(posedge MCLK);
  endtask
  task automatic run(input int la, input int n);
    adc_smp_t l, r;
    for (int i = 0; i < n + la; i++) begin
      lfsr_r = lfsr(lfsr_r);
      l = (i == 0) ? 24'h7FFFFF : lfsr_r[23:0];
      lfsr_r = lfsr(lfsr_r);
      r = (i == 1) ? 24'h800000 : {lfsr_r[23:1], 1'b0};
      hl.push_front(l);
      hr.push_front(r);
      src.send(l, r, int'(lfsr_r[1:0]));
      check("sub", SUB_OUT, sat(48'(l) + 48'(r >>> 1)));
      if (i >= la) begin
        check("left", L_OUT, post5(hl[la], post_c));
        check("right", R_OUT, post5(hr[la], post_c));
      end
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end
  // Watchdog sized well above the expected run
  initial begin
    repeat (40000) @(posedge MCLK);
    fail_count++;
    $display("ERROR watchdog expected done seen timeout");
    summarize();
  end
  initial begin
    RST_B = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 10'h0;
    WDATA = 22'h0;
    repeat (12) @(posedge MCLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge MCLK);
    rchk("ctrl", `ADC_A_CTRL1, 22'h0);
    rchk("table", `ADC_TAB_M, 22'h0);
    rchk("unmapped", 10'h200, 22'h0);
    src.send(24'h123456, 24'h123456, 0);
    check("silent", L_OUT, 24'h0);
    $display("test reset done");
    lfsr_r = lfsr(lfsr_r);
    bus(1'b1, 1'b0, 10'h000, lfsr_r[21:0]);
    rchk("word", 10'h000, lfsr_r[21:0]);
    bus(1'b1, 1'b0, `ADC_A_CTRL1, 22'h3FFFCF);
    rchk("ctrl", `ADC_A_CTRL1, 22'h0);
    // Flat tables make the gain independent of the detector
    for (int i = 0; i < 33; i++) begin
      wr(10'(`ADC_TAB_M + i), 22'h100000);
      wr(10'(`ADC_TAB_S + i), 22'h100000);
    end
    wr(`ADC_P_WL, 22'h100000);
    wr(`ADC_P_WR, 22'h080000);
    wr(`ADC_P_BQ, 22'h040000);
    wr(`ADC_P_TC_M, src.tconst_word(-200.0, 48000.0));
    wr(`ADC_P_DECAY_M, src.decay_word(120.0));
    post_c = src.post_word(3.0517578125);
    wr(`ADC_P_POST, post_c);
    $display("test setup done");
    foreach (las[k]) begin
      wr(`ADC_P_LA, 22'(las[k]));
      wr(`ADC_P_HOLD_M, src.hold_word(0.001, 48000.0, las[k]));
      run((las[k] > `ADC_LA_MAX) ? `ADC_LA_MAX : las[k], 8);
    end
    rchk("gain", `ADC_A_STATUS, 22'h100000);
    $display("test dynamics done");
    post_c = 22'h100000;
    wr(`ADC_P_POST, post_c);
    wr(`ADC_P_LA, 22'h0);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 1'b0, `ADC_A_CTRL1, 22'(c << 4));
      rchk("select", `ADC_A_CTRL1, 22'(c));
      if (c == 0) run(0, 8);
      else begin
        repeat (60) src.send(24'h100000, 24'h100000, 0);
        check("shelf", (L_OUT > 24'h0FD70A) && (L_OUT < 24'h1028F6), 1'b1);
      end
    end
    $display("test de-emphasis done");
    summarize();
  end
endmodule // testbench
